// ---- core/pfif_pkg.sv ----
/*
 * power fault interrupt flag package: register offsets, field positions,
 * reset values and the implemented-bit masks.
 * assumes an 8-bit register port with a small word address.
 */
package pfif_pkg;

    // ==========================================================
    // register map (word addresses)
    localparam int PFIF_ADDR_W = 4;
    localparam logic [PFIF_ADDR_W-1:0] PFIF_FLAGS_OFS = 4'h0;
    localparam logic [PFIF_ADDR_W-1:0] PFIF_MASK_OFS = 4'h1;
    localparam logic [PFIF_ADDR_W-1:0] PFIF_POLSEL_OFS = 4'h2;

    // ==========================================================
    // flag register fields
    localparam int PFIF_OUT_UNDERVOLT_BIT = 7;
    localparam int PFIF_OVERTEMP_BIT = 6;
    localparam int PFIF_OUT_OVERCURRENT_BIT = 5;
    localparam int PFIF_OUT_OVERVOLT_BIT = 4;
    localparam int PFIF_VIN_OV_LOCKOUT_BIT = 1;
    localparam int PFIF_VIN_UV_LOCKOUT_BIT = 0;
    localparam logic [7:0] PFIF_FLAGS_IMPL = 8'hF3;

    // ==========================================================
    // lockout polarity select fields
    localparam int PFIF_VIN_UV_RISE_SEL_BIT = 0;
    localparam int PFIF_VIN_UV_FALL_SEL_BIT = 1;
    localparam int PFIF_VIN_OV_RISE_SEL_BIT = 2;
    localparam int PFIF_VIN_OV_FALL_SEL_BIT = 3;
    localparam logic [7:0] PFIF_POLSEL_IMPL = 8'h0F;

    // ==========================================================
    // reset values
    localparam logic [7:0] PFIF_FLAGS_RST = 8'h00;
    localparam logic [7:0] PFIF_MASK_RST = 8'h00;
    localparam logic [7:0] PFIF_POLSEL_RST = 8'h05;
    localparam logic [7:0] PFIF_RDATA_RST = 8'h00;

endpackage

// ---- core/pfif_edge_det.sv ----
/*
 * edge detector for the vin lockout comparator levels.
 * assumes levels already synchronous to ref_clk_i; pulses are combinational
 * and one cycle long, valid in the cycle the new level is first seen.
 */
`timescale 1ns/1ps

module pfif_edge_det #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // levels in, edges out
    input wire logic [W-1:0] level_i,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);

    // ==========================================================
    // history
    logic [W-1:0] prev_reg;
    logic [W-1:0] prev_next;

    if (W < 1)
    begin : g_chk
        $error("pfif_edge_det: W must be at least 1");
    end

    always_comb
    begin
        prev_next = level_i;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prev_reg <= '0;
        end
        else
        begin
            prev_reg <= prev_next;
        end
    end

    // ==========================================================
    // edges, one per lane
    for (genvar i = 0; i < W; i++)
    begin : g_lane
        assign rise_o[i] = level_i[i] & ~prev_reg[i];
        assign fall_o[i] = ~level_i[i] & prev_reg[i];
    end

endmodule

// ---- core/pfif_flags.sv ----
/*
 * power fault interrupt flag register with mask, lockout polarity selects
 * and one level interrupt output.
 * assumes fault levels synchronous to ref_clk_i and a register master that
 * never issues read and write strobes in the same cycle.
 */
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module pfif_flags
    import pfif_pkg::*;
#(
    parameter int ADDR_W = PFIF_ADDR_W
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [7:0] rd_data_o,
    // fault levels from the supervisors
    input wire logic out_undervolt_i,
    input wire logic overtemp_i,
    input wire logic out_overcurrent_i,
    input wire logic out_overvolt_i,
    input wire logic vin_ov_i,
    input wire logic vin_uv_i,
    // interrupt and status
    output logic irq_o,
    output logic [7:0] flags_o
);

    // ==========================================================
    // parameter check
    if (ADDR_W < PFIF_ADDR_W)
    begin : g_chk
        $error("pfif_flags: ADDR_W too small for the register map");
    end

    // ==========================================================
    // state
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] polsel_reg;
    logic [7:0] polsel_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic irq_reg;
    logic irq_next;

    logic [1:0] vin_rise;
    logic [1:0] vin_fall;
    logic [7:0] set_ev;
    logic wr_flags;
    logic wr_mask;
    logic wr_polsel;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [PFIF_ADDR_W-1:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    // ==========================================================
    // lockout edges: lane 0 undervoltage, lane 1 overvoltage
    pfif_edge_det #(
        .W(2)
    ) u_vin_edge (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .level_i({vin_ov_i, vin_uv_i}),
        .rise_o(vin_rise),
        .fall_o(vin_fall)
    );

    // ==========================================================
    // set events; the mask never gates these, only the interrupt
    always_comb
    begin
        set_ev = 8'h00;
        set_ev[PFIF_OUT_UNDERVOLT_BIT] = out_undervolt_i;
        set_ev[PFIF_OVERTEMP_BIT] = overtemp_i;
        set_ev[PFIF_OUT_OVERCURRENT_BIT] = out_overcurrent_i;
        set_ev[PFIF_OUT_OVERVOLT_BIT] = out_overvolt_i;
        set_ev[PFIF_VIN_OV_LOCKOUT_BIT] = (vin_rise[1] & polsel_reg[PFIF_VIN_OV_RISE_SEL_BIT])
            | (vin_fall[1] & polsel_reg[PFIF_VIN_OV_FALL_SEL_BIT]);
        set_ev[PFIF_VIN_UV_LOCKOUT_BIT] = (vin_rise[0] & polsel_reg[PFIF_VIN_UV_RISE_SEL_BIT])
            | (vin_fall[0] & polsel_reg[PFIF_VIN_UV_FALL_SEL_BIT]);
    end

    // ==========================================================
    // register next values
    always_comb
    begin
        wr_flags = wr_en_i && hit(addr_i, PFIF_FLAGS_OFS);
        wr_mask = wr_en_i && hit(addr_i, PFIF_MASK_OFS);
        wr_polsel = wr_en_i && hit(addr_i, PFIF_POLSEL_OFS);

        // write stores the value; the or-in of events lets a set win over a clear
        flags_next = (wr_flags ? wr_data_i : flags_reg) | set_ev;
        flags_next = flags_next & PFIF_FLAGS_IMPL;
        mask_next = wr_mask ? (wr_data_i & PFIF_FLAGS_IMPL) : mask_reg;
        polsel_next = wr_polsel ? (wr_data_i & PFIF_POLSEL_IMPL) : polsel_reg;

        // irq follows the flag register it will sit beside, so no skew
        irq_next = |(flags_next & mask_next);

        rd_data_next = 8'h00;
        if (rd_en_i)
        begin
            if (hit(addr_i, PFIF_FLAGS_OFS))
            begin
                rd_data_next = flags_reg;
            end
            else if (hit(addr_i, PFIF_MASK_OFS))
            begin
                rd_data_next = mask_reg;
            end
            else if (hit(addr_i, PFIF_POLSEL_OFS))
            begin
                rd_data_next = polsel_reg;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            flags_reg <= PFIF_FLAGS_RST;
            mask_reg <= PFIF_MASK_RST;
            polsel_reg <= PFIF_POLSEL_RST;
            rd_data_reg <= PFIF_RDATA_RST;
            irq_reg <= 1'b0;
        end
        else
        begin
            flags_reg <= flags_next;
            mask_reg <= mask_next;
            polsel_reg <= polsel_next;
            rd_data_reg <= rd_data_next;
            irq_reg <= irq_next;
        end
    end

    // ==========================================================
    // outputs
    assign rd_data_o = rd_data_reg;
    assign irq_o = irq_reg;
    assign flags_o = flags_reg;

    // ==========================================================
    // checks
    property p_uv_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        out_undervolt_i |=> flags_reg[PFIF_OUT_UNDERVOLT_BIT];
    endproperty
    a_uv_set: assert property (p_uv_set)
        else $error("undervoltage did not set its flag");

    property p_uv_quiet;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (!out_undervolt_i && !flags_reg[PFIF_OUT_UNDERVOLT_BIT]
            && !(wr_en_i && hit(addr_i, PFIF_FLAGS_OFS) && wr_data_i[PFIF_OUT_UNDERVOLT_BIT]))
        |=> !flags_reg[PFIF_OUT_UNDERVOLT_BIT];
    endproperty
    a_uv_quiet: assert property (p_uv_quiet)
        else $error("undervoltage flag set without cause");

    property p_ot_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        overtemp_i |=> flags_reg[PFIF_OVERTEMP_BIT];
    endproperty
    a_ot_set: assert property (p_ot_set)
        else $error("overtemperature did not set its flag");

    property p_oc_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        out_overcurrent_i |=> flags_o[PFIF_OUT_OVERCURRENT_BIT];
    endproperty
    a_oc_set: assert property (p_oc_set)
        else $error("overcurrent did not set its flag");

    property p_ov_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        out_overvolt_i |=> flags_o[PFIF_OUT_OVERVOLT_BIT];
    endproperty
    a_ov_set: assert property (p_ov_set)
        else $error("output overvoltage did not set its flag");

    property p_unimpl_zero;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rd_en_i && hit(addr_i, PFIF_FLAGS_OFS) |=> (rd_data_o[3:2] == 2'b00) && (flags_o[3:2] == 2'b00);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented flag bits read nonzero");

    property p_vin_ov_rise;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(vin_ov_i) && $stable(resetn_i) && polsel_reg[PFIF_VIN_OV_RISE_SEL_BIT]
        |=> flags_reg[PFIF_VIN_OV_LOCKOUT_BIT];
    endproperty
    a_vin_ov_rise: assert property (p_vin_ov_rise)
        else $error("ov lockout entry not flagged");

    property p_vin_ov_fall;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(vin_ov_i) && $stable(resetn_i) && polsel_reg[PFIF_VIN_OV_FALL_SEL_BIT]
        |=> flags_reg[PFIF_VIN_OV_LOCKOUT_BIT];
    endproperty
    a_vin_ov_fall: assert property (p_vin_ov_fall)
        else $error("ov lockout exit not flagged");

    property p_vin_uv_quiet;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (vin_uv_i && $past(vin_uv_i) && $stable(resetn_i) && !flags_reg[PFIF_VIN_UV_LOCKOUT_BIT] && !wr_en_i)
        |=> !flags_reg[PFIF_VIN_UV_LOCKOUT_BIT];
    endproperty
    a_vin_uv_quiet: assert property (p_vin_uv_quiet)
        else $error("uv lockout flagged with no edge");

    property p_mask_free;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        overtemp_i && (mask_reg == 8'h00) && !wr_en_i |=> flags_reg[PFIF_OVERTEMP_BIT] && !irq_o;
    endproperty
    a_mask_free: assert property (p_mask_free)
        else $error("masked flag misbehaved");

    property p_set_wins;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_en_i && hit(addr_i, PFIF_FLAGS_OFS) && (wr_data_i == 8'h00) && overtemp_i
        |=> flags_reg[PFIF_OVERTEMP_BIT] && (flags_reg[PFIF_OUT_OVERVOLT_BIT] == $past(out_overvolt_i));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clearing write beat a set");

    property p_hold;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        flags_reg[PFIF_OUT_OVERCURRENT_BIT] && !(wr_en_i && hit(addr_i, PFIF_FLAGS_OFS))
        |=> flags_reg[PFIF_OUT_OVERCURRENT_BIT] [*1] ##1 1'b1;
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag dropped without a write");

    property p_read_data;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rd_en_i && hit(addr_i, PFIF_MASK_OFS)
        |=> rd_data_o == $past(mask_reg) ##1 ($past(rd_en_i) || rd_data_o == 8'h00);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read data wrong or not one cycle");

    property p_ot_quiet;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (!overtemp_i && !flags_reg[PFIF_OVERTEMP_BIT]
            && !(wr_en_i && hit(addr_i, PFIF_FLAGS_OFS) && wr_data_i[PFIF_OVERTEMP_BIT]))
        |=> !flags_reg[PFIF_OVERTEMP_BIT];
    endproperty
    a_ot_quiet: assert property (p_ot_quiet)
        else $error("overtemperature flag set without cause");

    property p_vin_uv_rise;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(vin_uv_i) && $stable(resetn_i) && polsel_reg[PFIF_VIN_UV_RISE_SEL_BIT]
        |=> flags_reg[PFIF_VIN_UV_LOCKOUT_BIT];
    endproperty
    a_vin_uv_rise: assert property (p_vin_uv_rise)
        else $error("uv lockout entry not flagged");

    property p_vin_uv_fall;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(vin_uv_i) && $stable(resetn_i) && polsel_reg[PFIF_VIN_UV_FALL_SEL_BIT]
        |=> flags_reg[PFIF_VIN_UV_LOCKOUT_BIT];
    endproperty
    a_vin_uv_fall: assert property (p_vin_uv_fall)
        else $error("uv lockout exit not flagged");

    property p_wr_clear;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (wr_en_i && hit(addr_i, PFIF_FLAGS_OFS) && (wr_data_i == 8'h00)
            && !(out_undervolt_i || overtemp_i || out_overcurrent_i || out_overvolt_i))
        |=> flags_o[PFIF_OUT_UNDERVOLT_BIT:PFIF_OUT_OVERVOLT_BIT] == 4'h0;
    endproperty
    a_wr_clear: assert property (p_wr_clear)
        else $error("clearing write left a fault flag set");

    property p_rd_idle;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !rd_en_i |=> rd_data_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero without a read");

endmodule

// ---- verification/pfif_testbench.sv ----
/*
 * self-checking bench for the power fault flag register: reset values,
 * fault flags, lockout edge selects, mask and interrupt, random traffic.
 * assumes pfif_pkg compiled first and the design's own assertions bound inside.
 */
`timescale 1ns/1ps

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module testbench;
    import pfif_pkg::*;

    // ==========================================================
    // signals
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [3:0] lv = 4'h0;
    logic [1:0] vin = 2'h0;
    logic [7:0] rd_data_o;
    logic [7:0] flags_o;
    logic irq_o;
    int failures = 0;
    int samples_checked = 0;

    pfif_flags DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr), .wr_data_i(wd),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data_o), .out_undervolt_i(lv[3]),
        .overtemp_i(lv[2]), .out_overcurrent_i(lv[1]), .out_overvolt_i(lv[0]),
        .vin_ov_i(vin[1]), .vin_uv_i(vin[0]), .irq_o(irq_o), .flags_o(flags_o));

    initial
    begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // next flag value: a write replaces, then every event of the cycle is or-ed on top
    function automatic logic [7:0] nxt(input logic [7:0] e, input logic w, input logic [7:0] d,
        input logic [5:0] n, input logic [1:0] p, input logic [7:0] pol);
        logic [7:0] f;
        f = w ? (d & 8'hF3) : e;
        f = f | {n[5:2], 4'h0};
        f[1] = f[1] | (pol[2] & n[1] & ~p[1]) | (pol[3] & ~n[1] & p[1]);
        f[0] = f[0] | (pol[0] & n[0] & ~p[0]) | (pol[1] & ~n[0] & p[0]);
        return f;
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wd <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk_i);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk_i);
        rd_en <= 1'b0;
        #1;
        `CHK(rd_data_o, e)
    endtask

    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial
    begin
        repeat (6000) @(posedge ref_clk_i);
        failures++;
        report_and_stop();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        logic [31:0] r;
        logic [7:0] e;
        logic [7:0] m;
        logic [7:0] pol;
        logic [5:0] n;
        logic [1:0] p;
        logic w;
        r = 32'h00014B2E;
        repeat (8) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        rd(4'h2, 8'h05);
        @(posedge ref_clk_i);
        #1;
        `CHK(rd_data_o, 8'h00)
        wr(4'h5, 8'hFF);
        rd(4'h5, 8'h00);
        rd(4'h0, 8'h00);
        wr(4'h1, 8'hFF);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk_i);
            lv[i] <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
            #1;
            `CHK(flags_o, 8'h10 << i)
            `CHK(irq_o, 1'b1)
            wr(4'h0, 8'h00);
            `CHK(flags_o, 8'h10 << i)
            @(posedge ref_clk_i);
            lv[i] <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
            #1;
            `CHK(flags_o, 8'h10 << i)
            wr(4'h0, 8'h00);
            `CHK(flags_o, 8'h00)
            `CHK(irq_o, 1'b0)
        end
        wr(4'h1, 8'h0C);
        rd(4'h1, 8'h00);
        @(posedge ref_clk_i);
        lv[2] <= 1'b1;
        @(posedge ref_clk_i);
        lv[2] <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        `CHK(flags_o, 8'h40)
        `CHK(irq_o, 1'b0)
        wr(4'h0, 8'hFF);
        rd(4'h0, 8'hF3);
        `CHK(irq_o, 1'b0)
        wr(4'h1, 8'h01);
        `CHK(irq_o, 1'b1)
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        `CHK(flags_o, 8'h00)
        `CHK(irq_o, 1'b0)
        `CHK(rd_data_o, 8'h00)
        @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        wr(4'h2, 8'hF5);
        rd(4'h2, 8'h05);
        for (int k = 0; k < 16; k++)
        begin
            pol = {4'h0, k[3:0] & 4'h0 | (k[3:2] == 2'd0 ? 4'h0 : k[3:2] == 2'd1 ? 4'h5 :
                k[3:2] == 2'd2 ? 4'hA : 4'hF)};
            wr(4'h2, pol);
            wr(4'h0, 8'h00);
            @(posedge ref_clk_i);
            vin[k[1]] <= ~k[0];
            @(posedge ref_clk_i);
            #1;
            e = ((pol[2 * k[1]] & ~k[0]) | (pol[2 * k[1] + 1] & k[0])) ? (8'h01 << k[1]) : 8'h00;
            `CHK(flags_o, e)
        end
        r = lfsr(r);
        m = r[7:0] & 8'hF3;
        wr(4'h1, m);
        wr(4'h0, 8'h00);
        e = 8'h00;
        p = vin;
        for (int k = 0; k < 400; k++)
        begin
            r = lfsr(r);
            n = {r[5:2] & r[9:6] & r[13:10], r[17:16]};
            w = (k % 16) == 15;
            @(posedge ref_clk_i);
            {lv, vin} <= n;
            addr <= 4'h0;
            wr_en <= w;
            wd <= r[31:24];
            #1;
            `CHK(flags_o, e)
            `CHK(irq_o, |(e & m))
            e = nxt(e, w, r[31:24], n, p, pol);
            p = n[1:0];
        end
        @(posedge ref_clk_i);
        wr_en <= 1'b0;
        #1;
        `CHK(flags_o, e)
        `CHK(irq_o, |(e & m))
        report_and_stop();
    end
endmodule
